// [osc_cmd_top.sv]
// Scroll command decoder with addressing pointer, APB slave and display RAM
`timescale 1ns/100ps
`default_nettype none
`include "osc_defs.svh"
module osc_cmd_top #(
  parameter int PAGES = 12,  // Display RAM pages
  parameter int COLS  = 128  // Display RAM columns
) (
  input  wire logic        pclk,    // Bus clock, 100 MHz
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB access phase
  input  wire logic        pwrite,  // APB direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic [31:0]      prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr  // APB error, unmapped offset
);
  osc_pkg::osc_state_e st_q;
  osc_pkg::osc_win_s   win;
  logic [7:0]  op_q;
  logic [2:0]  need_q;
  logic [2:0]  idx_q;
  logic [7:0]  pbuf_q [7];
  logic [7:0]  pfull  [7];
  logic [1:0]  mode_q;
  logic [6:0]  cs_q;
  logic [6:0]  ce_q;
  logic [3:0]  ps_q;
  logic [3:0]  pe_q;
  logic [6:0]  top_q;
  logic [6:0]  arows_q;
  logic [6:0]  rows_q;
  logic        setup_q;
  logic        active_q;
  logic [3:0]  page_q;
  logic [6:0]  col_q;
  logic [7:0]  ram_rd;
  logic        busy;
  logic [31:0] rd_val;
  logic        hit;
  logic        cmd_hit;
  logic        take;
  logic        byte_v;
  logic        bdc;
  logic [7:0]  bval;
  logic [2:0]  np;
  logic        is_cmd;
  logic        last;
  logic        exec;
  logic [7:0]  op;
  logic        ram_we;
  logic        scroll_go;

  // Parameter bytes that follow each opcode; unknown opcodes stand alone
  function automatic logic [2:0] osc_nparams(input logic [7:0] b);
    if (b == `OSC_OP_MODE) begin
      return 3'h1;
    end else if (b == `OSC_OP_COLR || b == `OSC_OP_PAGR || b == `OSC_OP_AREA) begin
      return 3'h2;
    end else if (b == `OSC_OP_VHR || b == `OSC_OP_VHL) begin
      return 3'h6;
    end else if (b == `OSC_OP_HSR || b == `OSC_OP_HSL ||
                 b == `OSC_OP_CSR || b == `OSC_OP_CSL) begin
      return 3'h7;
    end else begin
      return 3'h0;
    end
  endfunction

  // Address decode
  always_comb begin
    if (paddr == `OSC_OFF_CMD || paddr == `OSC_OFF_STAT || paddr == `OSC_OFF_ADDR ||
        paddr == `OSC_OFF_AREA || paddr == `OSC_OFF_ROWS || paddr == `OSC_OFF_RDAT) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Byte stream: a command write stalls in the access phase while shifting
  assign cmd_hit = pwrite && paddr == `OSC_OFF_CMD;
  assign take    = psel && penable && !pready && !(cmd_hit && busy);
  assign byte_v  = take && cmd_hit;
  assign bdc     = pwdata[`OSC_CMD_DC];
  assign bval    = pwdata[7:0];
  assign np      = osc_nparams(bval);
  assign is_cmd  = byte_v && !bdc;
  assign last    = is_cmd && st_q == osc_pkg::OSC_PARAM && idx_q == need_q - 3'h1;
  assign exec    = last || (is_cmd && st_q == osc_pkg::OSC_IDLE && np == 3'h0);
  assign op      = (st_q == osc_pkg::OSC_PARAM) ? op_q : bval;
  // Data bytes are dropped while scrolling so the moving image is not torn
  assign ram_we  = byte_v && bdc && !active_q;

  // Parameter set as it stands with the byte now arriving
  always_comb begin
    pfull        = pbuf_q;
    pfull[idx_q] = bval;
  end

  // Content scroll window from its parameter bytes; dummies are not checked
  assign win.sp    = pfull[1][3:0];
  assign win.ep    = pfull[3][3:0];
  assign win.sc    = pfull[5][6:0];
  assign win.ec    = pfull[6][6:0];
  assign win.left  = op == `OSC_OP_CSL;
  assign scroll_go = exec && (op == `OSC_OP_CSL || op == `OSC_OP_CSR);

  // Command byte collector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= osc_pkg::OSC_IDLE;
      op_q   <= 8'h00;
      need_q <= 3'h0;
      idx_q  <= 3'h0;
      pbuf_q <= '{default: 8'h00};
    end else begin
      case (st_q)
        osc_pkg::OSC_IDLE: begin
          if (is_cmd && np != 3'h0) begin
            st_q   <= osc_pkg::OSC_PARAM;
            op_q   <= bval;
            need_q <= np;
            idx_q  <= 3'h0;
          end
        end
        osc_pkg::OSC_PARAM: begin
          if (is_cmd) begin
            pbuf_q[idx_q] <= bval;
            idx_q         <= idx_q + 3'h1;
            if (last) begin
              st_q <= osc_pkg::OSC_IDLE;
            end
          end
        end
        default: st_q <= osc_pkg::OSC_IDLE;
      endcase
    end
  end

  // Mode, ranges, scroll area and scroll state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= `OSC_MODE_PAGE;
      cs_q     <= 7'h00;
      ce_q     <= 7'h7F;
      ps_q     <= 4'h0;
      pe_q     <= 4'hB;
      top_q    <= 7'h00;
      arows_q  <= `OSC_RST_ROWS;
      rows_q   <= `OSC_RST_ROWS;
      setup_q  <= 1'b0;
      active_q <= 1'b0;
    end else begin
      if (take && pwrite && paddr == `OSC_OFF_ROWS) begin
        rows_q <= pwdata[6:0];
      end
      if (exec) begin
        if (op == `OSC_OP_MODE && pfull[0][1:0] != 2'h3) begin
          mode_q <= pfull[0][1:0];
        end else if (op == `OSC_OP_COLR) begin
          cs_q <= pfull[0][6:0];
          ce_q <= pfull[1][6:0];
        end else if (op == `OSC_OP_PAGR) begin
          ps_q <= pfull[0][3:0];
          pe_q <= pfull[1][3:0];
        end else if (op == `OSC_OP_AREA) begin
          top_q   <= pfull[0][6:0];
          arows_q <= (pfull[1][6:0] > rows_q) ? rows_q : pfull[1][6:0];
        end else if (op == `OSC_OP_HSR || op == `OSC_OP_HSL || op == `OSC_OP_VHR ||
                     op == `OSC_OP_VHL) begin
          // A setup during motion would corrupt RAM, so it is refused
          setup_q <= setup_q || !active_q;
        end else if (op == `OSC_OP_GO) begin
          active_q <= active_q || setup_q;
        end else if (op == `OSC_OP_STOP) begin
          active_q <= 1'b0;
        end
      end
    end
  end

  // RAM pointer: set by address commands, stepped by each data byte written to RAM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= 4'h0;
      col_q  <= 7'h00;
    end else if (ram_we) begin
      if (mode_q == `OSC_MODE_PAGE) begin
        col_q <= (col_q == 7'(COLS - 1)) ? 7'h00 : col_q + 7'h01;
      end else if (mode_q == `OSC_MODE_VERT) begin
        if (page_q == pe_q) begin
          page_q <= ps_q;
          col_q  <= (col_q == ce_q) ? cs_q : col_q + 7'h01;
        end else begin
          page_q <= page_q + 4'h1;
        end
      end else begin
        if (col_q == ce_q) begin
          col_q  <= cs_q;
          page_q <= (page_q == pe_q) ? ps_q : page_q + 4'h1;
        end else begin
          col_q <= col_q + 7'h01;
        end
      end
    end else if (exec) begin
      if (op == `OSC_OP_COLR) begin
        col_q <= pfull[0][6:0];
      end else if (op == `OSC_OP_PAGR) begin
        page_q <= pfull[0][3:0];
      end else if (st_q == osc_pkg::OSC_IDLE && mode_q == `OSC_MODE_PAGE) begin
        if (bval[7:4] == 4'hB) begin
          page_q <= bval[3:0];
        end else if (bval[7:4] == 4'h0) begin
          col_q[3:0] <= bval[3:0];
        end else if (bval[7:4] == 4'h1) begin
          col_q[6:4] <= bval[2:0];
        end
      end
    end
  end

  osc_shift_ram #(
    .PAGES (PAGES),
    .COLS  (COLS)
  ) u_ram (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (ram_we),
    .wr_page (page_q),
    .wr_col  (col_q),
    .wr_data (bval),
    .rd_page (page_q),
    .rd_col  (col_q),
    .go      (scroll_go),
    .win     (win),
    .rd_data (ram_rd),
    .busy    (busy)
  );

  // Read mux; RAM reads show zero during motion
  always_comb begin
    rd_val = 32'h0;
    if (paddr == `OSC_OFF_STAT) begin
      rd_val[`OSC_ST_ACT]                = active_q;
      rd_val[`OSC_ST_BUSY]               = busy;
      rd_val[`OSC_ST_MODE+1:`OSC_ST_MODE] = mode_q;
      rd_val[`OSC_ST_PEND]               = st_q == osc_pkg::OSC_PARAM;
      rd_val[`OSC_ST_SETUP]              = setup_q;
    end else if (paddr == `OSC_OFF_ADDR) begin
      rd_val[3:0]                    = page_q;
      rd_val[`OSC_AD_COL+6:`OSC_AD_COL] = col_q;
    end else if (paddr == `OSC_OFF_AREA) begin
      rd_val[6:0]                      = top_q;
      rd_val[`OSC_AR_ROWS+6:`OSC_AR_ROWS] = arows_q;
    end else if (paddr == `OSC_OFF_ROWS) begin
      rd_val[6:0] = rows_q;
    end else if (paddr == `OSC_OFF_RDAT && !active_q) begin
      rd_val[7:0] = ram_rd;
    end
  end

  // APB answer: one wait state, longer while a shift holds a command write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= take;
      pslverr <= take && !hit;
      prdata  <= (take && !pwrite) ? rd_val : 32'h0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_area_hold;
    is_cmd && st_q == osc_pkg::OSC_PARAM && op_q == `OSC_OP_AREA && !last |=> $stable(top_q);
  endproperty
  a_area_hold: assert property (p_area_hold) else $error("area changed early");
  property p_area_clamp;
    exec && op == `OSC_OP_AREA && pfull[1][6:0] > rows_q |=> arows_q == $past(rows_q);
  endproperty
  a_area_clamp: assert property (p_area_clamp) else $error("area rows not clamped");
  property p_cs_full; scroll_go |-> st_q == osc_pkg::OSC_PARAM && idx_q == 3'h6; endproperty
  a_cs_full: assert property (p_cs_full) else $error("scroll before full sequence");
  property p_shift_run;
    scroll_go && win.sp == win.ep && win.sc < win.ec && int'(win.ep) < PAGES |=> busy [*2];
  endproperty
  a_shift_run: assert property (p_shift_run) else $error("shift did not run");
  property p_dir; scroll_go |-> win.left == (op_q == `OSC_OP_CSL); endproperty
  a_dir: assert property (p_dir) else $error("shift direction wrong");
  property p_mode;
    exec && op == `OSC_OP_MODE && pfull[0][1:0] == `OSC_MODE_VERT |=> mode_q == `OSC_MODE_VERT;
  endproperty
  a_mode: assert property (p_mode) else $error("vertical mode not taken");
  property p_page;
    exec && st_q == osc_pkg::OSC_IDLE && mode_q == `OSC_MODE_PAGE && bval[7:4] == 4'hB
      |=> page_q == $past(bval[3:0]);
  endproperty
  a_page: assert property (p_page) else $error("page not set");
  property p_data; byte_v && bdc |-> ram_we == !active_q; endproperty
  a_data: assert property (p_data) else $error("data write gating wrong");
  property p_go; exec && op == `OSC_OP_GO && setup_q |=> active_q; endproperty
  a_go: assert property (p_go) else $error("scroll not started");
  property p_stop; exec && op == `OSC_OP_STOP |=> !active_q ##1 !active_q; endproperty
  a_stop: assert property (p_stop) else $error("scroll not stopped");
  property p_blocked; active_q && byte_v && bdc |=> $stable(col_q) && $stable(page_q); endproperty
  a_blocked: assert property (p_blocked) else $error("pointer moved in scroll");

  c_left:  cover property (scroll_go && win.left ##1 busy);
  c_right: cover property (scroll_go && !win.left ##1 busy);
  c_clamp: cover property (exec && op == `OSC_OP_AREA && pfull[1][6:0] > rows_q);
  c_stall: cover property (psel && penable && cmd_hit && busy);
endmodule
`default_nettype wire

// [osc_cmd_top_tb_top.sv]
// Self-checking bench for the scroll command block
`timescale 1ns/100ps
`default_nettype none
`include "osc_defs.svh"
module osc_cmd_top_tb_top;
  logic        pclk;       // Bus clock
  logic        presetn;    // Reset, active low
  logic        psel;       // APB select
  logic        penable;    // APB access phase
  logic        pwrite;     // APB direction
  logic [7:0]  paddr;      // APB address
  logic [31:0] pwdata;     // APB write data
  logic [31:0] prdata;     // APB read data
  logic        pready;     // APB ready
  logic        pslverr;    // APB error
  int          mismatches; // Failed compares
  int          cmp_count;  // All compares

  // 100 MHz clock
  always #5 pclk = ~pclk;

  osc_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
                       .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                       .pwdata(pwdata));

  osc_cmd_top #(.PAGES(12), .COLS(128)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic end_of_test;
    mismatches += host.tmo;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register read, value and error flag both judged
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    host.rd(a, q, e);
    chk(what, exp, q);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  // RAM byte at a page and column, pointer set in page mode
  task automatic peek(input logic [3:0] p, input logic [6:0] c, input logic [7:0] exp);
    host.send('{{4'hB, p}, {5'h02, c[6:4]}, {4'h0, c[3:0]}});
    rchk("ram", `OSC_OFF_RDAT, {24'h0, exp});
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rchk("rows", `OSC_OFF_ROWS, 32'h60);
    rchk("stat", `OSC_OFF_STAT, 32'h08);
    rchk("addr", `OSC_OFF_ADDR, 32'h0);
    rchk("area", `OSC_OFF_AREA, 32'h6000);
    host.wr(`OSC_OFF_STAT, 32'hFF);
    rchk("stat ro", `OSC_OFF_STAT, 32'h08);
    host.rd(8'h18, q, e);
    chk("unmapped", 32'h1, {31'h0, e});
    host.wr(`OSC_OFF_ROWS, 32'h20);
    rchk("rows", `OSC_OFF_ROWS, 32'h20);
    $display("test reset done");
  endtask

  // Every mode code, then the unused code that must be ignored
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      host.send('{8'h20, 8'(m)});
      rchk("mode", `OSC_OFF_STAT, (m == 3) ? 32'h08 : 32'(m << 2));
    end
    $display("test modes done");
  endtask

  task automatic t_page;
    host.send('{8'hB1, 8'h17, 8'h08});
    rchk("addr", `OSC_OFF_ADDR, 32'h7801);
    host.put(1'b1, 8'hAA);
    rchk("addr step", `OSC_OFF_ADDR, 32'h7901);
    peek(4'h1, 7'd120, 8'hAA);
    $display("test page done");
  endtask

  task automatic t_vert;
    host.send('{8'h20, 8'h01});
    host.send('{8'h21, 8'h78, 8'h78});
    host.send('{8'h22, 8'h00, 8'h03});
    rchk("addr", `OSC_OFF_ADDR, 32'h7800);
    for (int i = 0; i < 4; i++) host.put(1'b1, 8'h50 + 8'(i));
    rchk("addr wrap", `OSC_OFF_ADDR, 32'h7800);
    host.send('{8'h20, 8'h00});
    host.send('{8'h21, 8'h7E, 8'h7F});
    host.send('{8'h22, 8'h04, 8'h05});
    for (int i = 0; i < 4; i++) host.put(1'b1, 8'h60 + 8'(i));
    rchk("addr horz", `OSC_OFF_ADDR, 32'h7E04);
    host.send('{8'h20, 8'h02});
    peek(4'h5, 7'd126, 8'h62);
    peek(4'h2, 7'd120, 8'h52);
    peek(4'h3, 7'd120, 8'h53);
    $display("test vert done");
  endtask

  task automatic t_area;
    host.send('{8'hA3, 8'h05});
    rchk("area early", `OSC_OFF_AREA, 32'h6000);
    rchk("stat mid", `OSC_OFF_STAT, 32'h18);
    host.put(1'b0, 8'h40);
    rchk("area clamp", `OSC_OFF_AREA, 32'h2005);
    host.send('{8'hA3, 8'h00, 8'h20});
    rchk("area equal", `OSC_OFF_AREA, 32'h2000);
    $display("test area done");
  endtask

  // Left then right shift of a three-column window; column 11 lies outside
  task automatic t_shift;
    logic [7:0] seed[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [7:0] lft[4] = '{8'h22, 8'h33, 8'h00, 8'h44};
    logic [7:0] rgt[4] = '{8'h00, 8'h22, 8'h33, 8'h44};
    host.send('{8'hB0, 8'h10, 8'h08});
    foreach (seed[i]) host.put(1'b1, seed[i]);
    host.send('{8'h2D, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h08});
    rchk("stat mid", `OSC_OFF_STAT, 32'h18);
    host.put(1'b0, 8'h0A);
    host.scroll_gap();
    foreach (lft[i]) peek(4'h0, 7'(8 + i), lft[i]);
    host.send('{8'h2C, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h08, 8'h0A});
    foreach (rgt[i]) peek(4'h0, 7'(8 + i), rgt[i]);
    $display("test shift done");
  endtask

  task automatic t_scroll;
    host.send('{8'h2F});
    rchk("no setup", `OSC_OFF_STAT, 32'h08);
    host.send('{8'h2E});
    host.send('{8'h26, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h7F});
    rchk("setup", `OSC_OFF_STAT, 32'h28);
    host.send('{8'h2F});
    rchk("active", `OSC_OFF_STAT, 32'h29);
    host.send('{8'h2E});
    rchk("stopped", `OSC_OFF_STAT, 32'h28);
    $display("test scroll done");
  endtask

  // Reset for ten cycles, then the tests in order
  initial begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    mismatches = 0;
    cmp_count  = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_page();
    t_vert();
    t_area();
    t_shift();
    t_scroll();
    end_of_test();
  end

  // Watchdog, well beyond the roughly 1,250 cycles the tests need
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire

// [osc_defs.svh]
// Register offsets, field positions, opcodes and reset values of the scroll command block
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
`define OSC_OFF_CMD   8'h00
`define OSC_OFF_STAT  8'h04
`define OSC_OFF_ADDR  8'h08
`define OSC_OFF_AREA  8'h0C
`define OSC_OFF_ROWS  8'h10
`define OSC_OFF_RDAT  8'h14
`define OSC_CMD_DC    8
`define OSC_ST_ACT    0
`define OSC_ST_BUSY   1
`define OSC_ST_MODE   2
`define OSC_ST_PEND   4
`define OSC_ST_SETUP  5
`define OSC_AD_COL    8
`define OSC_AR_ROWS   8
`define OSC_OP_MODE   8'h20
`define OSC_OP_COLR   8'h21
`define OSC_OP_PAGR   8'h22
`define OSC_OP_AREA   8'hA3
`define OSC_OP_HSR    8'h26
`define OSC_OP_HSL    8'h27
`define OSC_OP_VHR    8'h29
`define OSC_OP_VHL    8'h2A
`define OSC_OP_CSR    8'h2C
`define OSC_OP_CSL    8'h2D
`define OSC_OP_STOP   8'h2E
`define OSC_OP_GO     8'h2F
`define OSC_MODE_HORZ 2'h0
`define OSC_MODE_VERT 2'h1
`define OSC_MODE_PAGE 2'h2
`define OSC_RST_ROWS  7'h60
`endif

// [osc_host_model.sv]
// Host model: APB master sending command and data bytes to the scroll block
`timescale 1ns/100ps
`default_nettype none
`include "osc_defs.svh"
module osc_host_model #(
  parameter int REFRESH_CYCLES = 100 // Cycles per display refresh, arbitrary bench value
) (
  input  wire logic        pclk,    // Bus clock
  input  wire logic        pready,  // Slave ready
  input  wire logic        pslverr, // Slave error
  input  wire logic [31:0] prdata,  // Slave read data
  output logic             psel,    // Select
  output logic             penable, // Access phase
  output logic             pwrite,  // Direction, 1 write
  output logic [7:0]       paddr,   // Byte address
  output logic [31:0]      pwdata   // Write data
);
  logic scrolling; // Host view of scroll motion
  int   tmo;       // Waits that ran out

  // Idle bus from time zero
  initial begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    scrolling = 1'b0;
    tmo       = 0;
  end

  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 4000);
    if (n >= 4000) tmo++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask

  // Pixel data is dropped while the display is scrolling
  task automatic put(input logic dc, input logic [7:0] b);
    if (dc && scrolling) return;
    wr(`OSC_OFF_CMD, {23'h0, dc, b});
  endtask

  // Waits out a window shift before anything else touches the RAM
  task automatic wait_idle;
    logic [31:0] q;
    logic        e;
    int          n;
    n = 0;
    do begin
      rd(`OSC_OFF_STAT, q, e);
      n++;
    end while (q[`OSC_ST_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) tmo++;
  endtask

  // Two refresh periods after a content scroll, before the next one or new column data
  task automatic scroll_gap;
    wait_idle();
    repeat (2 * REFRESH_CYCLES) @(posedge pclk);
  endtask

  // Command with its parameters; setups are not changed mid-scroll
  task automatic send(input logic [7:0] s[$]);
    if (scrolling && s[0] inside {8'h26, 8'h27, 8'h29, 8'h2A}) return;
    foreach (s[i]) put(1'b0, s[i]);
    if (s[0] == `OSC_OP_GO) scrolling = 1'b1;
    if (s[0] == `OSC_OP_STOP) scrolling = 1'b0;
    if (s[0] inside {`OSC_OP_CSL, `OSC_OP_CSR}) scroll_gap();
  endtask
endmodule
`default_nettype wire

// [osc_pkg.sv]
// Types shared by the scroll command block
package osc_pkg;
  typedef enum logic [1:0] {
    OSC_IDLE  = 2'b01,
    OSC_PARAM = 2'b10
  } osc_state_e;
  typedef struct packed {
    logic [3:0] sp;
    logic [3:0] ep;
    logic [6:0] sc;
    logic [6:0] ec;
    logic       left;
  } osc_win_s;
endpackage

// [osc_shift_ram.sv]
// Display RAM with a one-column window shift engine
`timescale 1ns/100ps
`default_nettype none
module osc_shift_ram #(
  parameter int PAGES = 12,
  parameter int COLS  = 128
) (
  input  wire logic              clk,     // Core clock
  input  wire logic              rst_n,   // Async reset, active low
  input  wire logic              wr_en,   // Host data byte write
  input  wire logic [3:0]        wr_page, // Write page
  input  wire logic [6:0]        wr_col,  // Write column
  input  wire logic [7:0]        wr_data, // Write byte
  input  wire logic [3:0]        rd_page, // Read page
  input  wire logic [6:0]        rd_col,  // Read column
  input  wire logic              go,      // Start one window shift
  input  wire osc_pkg::osc_win_s win,     // Window and direction
  output logic [7:0]             rd_data, // Registered read byte
  output logic                   busy     // Shift in progress
);
  logic [7:0]        mem [PAGES*COLS];
  logic [3:0]        p_q;
  logic [6:0]        c_q;
  osc_pkg::osc_win_s win_q;
  logic              tail;

  function automatic int osc_idx(input logic [3:0] p, input logic [6:0] c);
    return int'(p) * COLS + int'(c);
  endfunction

  // Last byte of a row is the freed column, cleared for the host to refill
  assign tail = win_q.left ? (c_q == win_q.ec) : (c_q == win_q.sc);

  // Shift moves stored bytes, one per cycle; host writes wait until idle
  always_ff @(posedge clk) begin
    if (busy) begin
      if (tail) begin
        mem[osc_idx(p_q, c_q)] <= 8'h00;
      end else if (win_q.left) begin
        mem[osc_idx(p_q, c_q)] <= mem[osc_idx(p_q, c_q + 7'h01)];
      end else begin
        mem[osc_idx(p_q, c_q)] <= mem[osc_idx(p_q, c_q - 7'h01)];
      end
    end else if (wr_en) begin
      mem[osc_idx(wr_page, wr_col)] <= wr_data;
    end
    rd_data <= mem[osc_idx(rd_page, rd_col)];
  end

  // Walk rows of the window; an inverted or oversized window is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy  <= 1'b0;
      p_q   <= 4'h0;
      c_q   <= 7'h00;
      win_q <= '0;
    end else if (!busy) begin
      if (go && win.sp <= win.ep && win.sc <= win.ec && int'(win.ep) < PAGES) begin
        busy  <= 1'b1;
        win_q <= win;
        p_q   <= win.sp;
        c_q   <= win.left ? win.sc : win.ec;
      end
    end else if (tail) begin
      c_q <= win_q.left ? win_q.sc : win_q.ec;
      if (p_q == win_q.ep) begin
        busy <= 1'b0;
      end else begin
        p_q <= p_q + 4'h1;
      end
    end else begin
      c_q <= win_q.left ? c_q + 7'h01 : c_q - 7'h01;
    end
  end
endmodule
`default_nettype wire
